// >>> rtl/fps_pkg.sv
// Package for the flyback protection supervisor: constants, register map, types
package fps_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 25000000;

  // Debounce and blanking times in microseconds and nanoseconds
  localparam int unsigned SUPPLY_OVP_DEBOUNCE_US = 100;
  localparam int unsigned BROWNOUT_DEBOUNCE_US   = 50000;
  localparam int unsigned UVP_STARTUP_BLANK_US   = 40000;
  localparam int unsigned LONG_RESTART_OFF_US    = 1000000;
  localparam int unsigned CS_SHORT_DEBOUNCE_NS   = 400;
  localparam int unsigned RECT_SHORT_BLANK_NS    = 200;
  localparam int unsigned CS_SHORT_MAX_ON_NS     = 2000;

  // Least times round up to whole cycles
  localparam int unsigned SUPPLY_OVP_DEBOUNCE_CYC =
    (SUPPLY_OVP_DEBOUNCE_US * 25 + 0);
  localparam int unsigned BROWNOUT_DEBOUNCE_CYC   = BROWNOUT_DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int unsigned UVP_STARTUP_BLANK_CYC   = UVP_STARTUP_BLANK_US * (CLK_HZ / 1000000);
  localparam int unsigned LONG_RESTART_OFF_CYC    = LONG_RESTART_OFF_US * (CLK_HZ / 1000000);
  localparam int unsigned CS_SHORT_DEBOUNCE_CYC   = (CS_SHORT_DEBOUNCE_NS * 25 + 999) / 1000;
  localparam int unsigned RECT_SHORT_BLANK_CYC    = (RECT_SHORT_BLANK_NS * 25 + 999) / 1000;
  // Longest time rounds down
  localparam int unsigned CS_SHORT_MAX_ON_CYC     = (CS_SHORT_MAX_ON_NS * 25) / 1000;

  // Cycle debounce counts
  localparam int unsigned BROWNIN_DEBOUNCE_CYCLES = 4;
  localparam int unsigned SENSE_OVP_CYCLES        = 4;
  localparam int unsigned SENSE_UVP_CYCLES        = 4;
  localparam int unsigned CS_SHORT_CYCLES         = 4;
  localparam int unsigned RECT_SHORT_CYCLES       = 4;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CAUSE  = 8'h08;

  // Control field positions and reset value
  localparam int unsigned CTRL_OVP_LATCH_BIT = 0;
  localparam int unsigned CTRL_UVP_LONG_BIT  = 1;
  localparam int unsigned CTRL_UNLATCH_BIT   = 2;
  localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Supervisor states
  typedef enum logic [2:0] {
    ST_CHARGE, ST_BROWNIN, ST_RUN, ST_RESTART, ST_LONG_OFF, ST_LATCHED
  } fps_state_t;

  // Comparator results from the analog front end
  typedef struct packed {
    logic supply_on;        // Supply above supply_turn_on_level
    logic supply_low;       // Supply below restart level
    logic supply_ovp;       // Supply above supply_ovp_level
    logic brownin_cur;      // Sense current above brownin_current_level
    logic brownout_cur;     // Sense current below brownout_current_level
    logic sense_ovp;        // Sampled sense voltage above sense_ovp_level
    logic sense_uvp;        // Sampled sense voltage below sense_uvp_level
    logic cs_limit;         // Current sense at cs_limit_level
    logic cs_short_ok;      // Current sense above cs_short_level
    logic rect_short;       // Current sense at rect_short_level
    logic overtemp;         // Junction above overtemp_level
  } fps_cmp_t;

  // Fault causes, one bit each
  typedef struct packed {
    logic overtemp;
    logic rect_short;
    logic cs_short;
    logic sense_uvp;
    logic sense_ovp;
    logic brownout;
    logic brownin_fail;
    logic supply_ovp;
  } fps_cause_t;

endpackage

// >>> rtl/fps_supervisor.sv
// Protection sequencer for a flyback controller with an AXI4-Lite register slave
//
// Behaviour
// - Clamp sense pin while switch conducts
// - Power and current limit fallback
// - Cycle current limit turns switch off
// - Start-up path on until supply on
// - No brown-in after start means restart
// - Output overvoltage restarts or latches
// - Output undervoltage restarts or long-restarts
// - Long restart off time, then supply check
// - Debounced supply overvoltage enters restart
// - Brown-in after debounced sense current cycles
// - Debounced low sense current is brownout
// - Overtemperature disables switching
// - Consecutive sense overvoltage cycles stop switching
// - Sense undervoltage cycles enter configured restart
// - Blank undervoltage after power-on
// - Low current sense caps on-time
// - Repeated low current sense enters restart
// - Rectifier short turns switch off after blanking
// - Repeated rectifier short enters restart
`timescale 1ns/100ps
`default_nettype none

module fps_supervisor
  import fps_pkg::*;
#(
  parameter int unsigned LONG_OFF_CYC  = LONG_RESTART_OFF_CYC,
  parameter int unsigned BROWNOUT_CYC  = BROWNOUT_DEBOUNCE_CYC,
  parameter int unsigned UVP_BLANK_CYC = UVP_STARTUP_BLANK_CYC,
  parameter int unsigned CNT_W         = 25
) (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // Analog comparator results and PWM request
  input  wire fps_cmp_t    cmp,
  input  wire logic        pwm_on_req,
  input  wire logic        protocol_fault,
  // Power stage controls
  output logic             gate_drive,
  output logic             hv_startup_en,
  output logic             sense_clamp_en,
  output logic             power_limit_en,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);

  // Saturating increment shared by the time debounce timers and the on-time and off-time counters
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  fps_state_t       state_q, state_d;
  logic             gate_q, prev_pwm_q;
  logic [CNT_W-1:0] on_cnt_q;
  logic [CNT_W-1:0] tmr_q;
  logic [CNT_W-1:0] vddovp_q, bro_q, blank_q;
  logic [7:0]       bri_q, ovp_q, uvp_q, css_q, rss_q;
  logic             cyc_csok_q, cyc_rss_q;
  logic [2:0]       ctrl_q;
  fps_cause_t       cause_q;

  wire cyc_start = pwm_on_req && !prev_pwm_q;
  wire switching = (state_q == ST_BROWNIN) || (state_q == ST_RUN);

  // Per-cycle pulse termination
  wire past_rss_blank = on_cnt_q >= CNT_W'(RECT_SHORT_BLANK_CYC);
  wire past_css_deb   = on_cnt_q >= CNT_W'(CS_SHORT_DEBOUNCE_CYC);
  wire css_low_now    = past_css_deb && !cmp.cs_short_ok && !cyc_csok_q;
  wire rss_now        = past_rss_blank && cmp.rect_short;
  wire cap_on         = css_low_now && (on_cnt_q >= CNT_W'(CS_SHORT_MAX_ON_CYC));
  wire kill_now       = cmp.cs_limit || rss_now || cap_on || cmp.overtemp;
  // Cycle boundary: falling edge of the gate ends a switching cycle
  wire cyc_end        = gate_q && (!pwm_on_req || kill_now);

  // Debounced fault conditions
  wire blank_done  = blank_q >= CNT_W'(UVP_BLANK_CYC);
  wire f_vddovp    = vddovp_q >= CNT_W'(SUPPLY_OVP_DEBOUNCE_CYC);
  wire f_brownout  = (state_q == ST_RUN) && (bro_q > CNT_W'(BROWNOUT_CYC));
  wire f_ovp       = ovp_q > 8'(SENSE_OVP_CYCLES);
  wire f_uvp       = blank_done && (uvp_q > 8'(SENSE_UVP_CYCLES));
  wire f_css       = css_q >= 8'(CS_SHORT_CYCLES);
  wire f_rss       = rss_q >= 8'(RECT_SHORT_CYCLES);
  wire brownin_ok  = bri_q >= 8'(BROWNIN_DEBOUNCE_CYCLES);
  wire brownin_bad = (state_q == ST_BROWNIN) && cmp.supply_low;
  wire any_fault   = switching && (f_vddovp || f_brownout || f_ovp || f_uvp
                     || f_css || f_rss || cmp.overtemp || brownin_bad);

  // Next state of the supervisor
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_CHARGE:   if (cmp.supply_on) state_d = ST_BROWNIN;
      ST_BROWNIN:  if (brownin_ok) state_d = ST_RUN;
      ST_RUN:      ;
      ST_RESTART:  if (cmp.supply_low) state_d = ST_CHARGE;
      ST_LONG_OFF: if (tmr_q >= CNT_W'(LONG_OFF_CYC)) state_d = ST_CHARGE;
      ST_LATCHED:  if (ctrl_q[CTRL_UNLATCH_BIT]) state_d = ST_RESTART;
    endcase
    if (any_fault) begin
      if (f_ovp && ctrl_q[CTRL_OVP_LATCH_BIT]) state_d = ST_LATCHED;
      else if (f_uvp && ctrl_q[CTRL_UVP_LONG_BIT]) state_d = ST_LONG_OFF;
      else state_d = ST_RESTART;
    end
  end

  // State, gate and on-time counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= ST_CHARGE;
      gate_q     <= 1'b0;
      prev_pwm_q <= 1'b0;
      on_cnt_q   <= '0;
      tmr_q      <= '0;
    end else if (clk_en) begin
      state_q    <= state_d;
      prev_pwm_q <= pwm_on_req;
      // Gate only in switching states; any kill term ends this pulse
      if (!switching || any_fault || kill_now || !pwm_on_req) gate_q <= 1'b0;
      else if (cyc_start) gate_q <= 1'b1;
      on_cnt_q <= gate_q ? sat_inc(on_cnt_q) : '0;
      tmr_q    <= (state_q == ST_LONG_OFF) ? sat_inc(tmr_q) : '0;
    end
  end

  // Per-cycle flags reset at the start of each pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_csok_q <= 1'b0;
      cyc_rss_q  <= 1'b0;
    end else if (clk_en) begin
      if (!gate_q) begin
        cyc_csok_q <= 1'b0;
        cyc_rss_q  <= 1'b0;
      end else begin
        cyc_csok_q <= cyc_csok_q | (cmp.cs_short_ok && past_css_deb);
        cyc_rss_q  <= cyc_rss_q | rss_now;
      end
    end
  end

  // Cycle debounce counters; one passing cycle clears each
  always_ff @(posedge aclk) begin
    if (!aresetn || !switching) begin
      bri_q <= '0;
      ovp_q <= '0;
      uvp_q <= '0;
      css_q <= '0;
      rss_q <= '0;
    end else if (clk_en && cyc_end) begin
      bri_q <= cmp.brownin_cur ? (bri_q == 8'hff ? bri_q : bri_q + 8'h01) : '0;
      ovp_q <= cmp.sense_ovp ? (ovp_q == 8'hff ? ovp_q : ovp_q + 8'h01) : '0;
      uvp_q <= cmp.sense_uvp ? (uvp_q == 8'hff ? uvp_q : uvp_q + 8'h01) : '0;
      // Pulses cut before the sense debounce never saw a valid reading
      css_q <= (!cyc_csok_q && past_css_deb) ?
               (css_q == 8'hff ? css_q : css_q + 8'h01) : '0;
      rss_q <= (cyc_rss_q || rss_now) ?
               (rss_q == 8'hff ? rss_q : rss_q + 8'h01) : '0;
    end
  end

  // Time debounce timers; supply OVP and brownout clear when their condition drops, the blanking timer only on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vddovp_q <= '0;
      bro_q    <= '0;
      blank_q  <= '0;
    end else if (clk_en) begin
      vddovp_q <= cmp.supply_ovp ? sat_inc(vddovp_q) : '0;
      bro_q    <= cmp.brownout_cur ? sat_inc(bro_q) : '0;
      blank_q  <= sat_inc(blank_q);
    end
  end

  // Power stage outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hv_startup_en  <= 1'b1;
      sense_clamp_en <= 1'b0;
      power_limit_en <= 1'b0;
    end else if (clk_en) begin
      hv_startup_en  <= (state_d == ST_CHARGE);
      sense_clamp_en <= gate_q && switching;
      power_limit_en <= protocol_fault;
    end
  end
  assign gate_drive = gate_q;

  // Fault cause record; hardware set wins over software clear
  wire [7:0] cause_set = any_fault ?
    {cmp.overtemp, f_rss, f_css, f_uvp, f_ovp, f_brownout, brownin_bad, f_vddovp} : 8'h00;

  // AXI4-Lite slave: one write and one read outstanding
  logic aw_hold_q, w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  wire wr_go   = aw_hold_q && w_hold_q && !s_bvalid;
  wire wr_ctrl = wr_go && (awaddr_q[7:2] == REG_CTRL[7:2]);
  wire wr_clr  = wr_go && (awaddr_q[7:2] == REG_CAUSE[7:2]);
  wire wr_ok   = wr_ctrl || wr_clr || (wr_go && awaddr_q[7:2] == REG_STATUS[7:2]);
  wire [7:0] clr_mask = (wr_clr && wstrb_q[0]) ? wdata_q[7:0] : 8'h00;
  wire [31:0] rd_word =
    (s_araddr[7:2] == REG_CTRL[7:2])   ? {29'h0, ctrl_q} :
    (s_araddr[7:2] == REG_STATUS[7:2]) ? {24'h0, 5'(state_q), hv_startup_en,
                                          power_limit_en, gate_q} :
    (s_araddr[7:2] == REG_CAUSE[7:2])  ? {24'h0, cause_q} : 32'h0;
  wire rd_hit = (s_araddr[7:2] == REG_CTRL[7:2]) || (s_araddr[7:2] == REG_STATUS[7:2])
                || (s_araddr[7:2] == REG_CAUSE[7:2]);

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
      ctrl_q    <= CTRL_RESET[2:0];
      cause_q   <= '0;
    end else if (clk_en) begin
      s_awready <= !aw_hold_q && !s_awready && !s_bvalid;
      s_wready  <= !w_hold_q && !s_wready && !s_bvalid;
      if (s_awvalid && s_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (wr_ctrl && wstrb_q[0]) ctrl_q <= wdata_q[2:0];
      else if (ctrl_q[CTRL_UNLATCH_BIT]) ctrl_q[CTRL_UNLATCH_BIT] <= 1'b0; // Self-clearing
      cause_q <= (cause_q & ~clr_mask) | cause_set;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= RESP_OKAY;
    end else if (clk_en) begin
      s_arready <= !s_arready && !s_rvalid && s_arvalid;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_word;
        s_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// >>> verif/fps_supervisor_asserts.sv
// Power-stage checks bound to the supervisor
`timescale 1ns/100ps
`default_nettype none

module fps_supervisor_asserts
  import fps_pkg::*;
(
  // Clock and reset
  input wire logic     aclk,
  input wire logic     aresetn,
  // Causes
  input wire fps_cmp_t cmp,
  input wire logic     protocol_fault,
  // Power stage
  input wire logic     gate_drive,
  input wire logic     hv_startup_en,
  input wire logic     sense_clamp_en,
  input wire logic     power_limit_en
);
  int unsigned on_cnt;
  int unsigned low_cnt;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // On-time counters; low one restarts if the sense recovers
  always_ff @(posedge aclk) begin
    on_cnt  <= (aresetn && gate_drive) ? on_cnt + 1 : 0;
    low_cnt <= (aresetn && gate_drive && !cmp.cs_short_ok) ? low_cnt + 1 : 0;
  end

  property p_clamp; $changed(gate_drive) |=> sense_clamp_en == $past(gate_drive); endproperty
  a_clamp: assert property (p_clamp) else $error("clamp lag wrong");
  property p_limit; $changed(protocol_fault) |=> power_limit_en == $past(protocol_fault); endproperty
  a_limit: assert property (p_limit) else $error("limit lag wrong");
  property p_cslim; gate_drive && cmp.cs_limit |=> !gate_drive; endproperty
  a_cslim: assert property (p_cslim) else $error("gate on past limit");
  property p_hv_gate; hv_startup_en |-> !gate_drive; endproperty
  a_hv_gate: assert property (p_hv_gate) else $error("gate while charging");
  property p_hv_fall; $fell(hv_startup_en) |-> $past(cmp.supply_on); endproperty
  a_hv_fall: assert property (p_hv_fall) else $error("charge stopped early");
  property p_otemp; cmp.overtemp |=> !gate_drive; endproperty
  a_otemp: assert property (p_otemp) else $error("gate on when hot");
  property p_rect; gate_drive && cmp.rect_short && on_cnt > RECT_SHORT_BLANK_CYC + 1
    |=> !gate_drive; endproperty
  a_rect: assert property (p_rect) else $error("gate on past short");
  property p_cap; low_cnt <= CS_SHORT_MAX_ON_CYC + 2; endproperty
  a_cap: assert property (p_cap) else $error("on-time not capped");
endmodule

bind fps_supervisor fps_supervisor_asserts i_chk (
  .aclk(aclk), .aresetn(aresetn), .cmp(cmp), .protocol_fault(protocol_fault),
  .gate_drive(gate_drive), .hv_startup_en(hv_startup_en),
  .sense_clamp_en(sense_clamp_en), .power_limit_en(power_limit_en));

`default_nettype wire

// >>> verif/fps_supervisor_tb.sv
// Self-checking bench for the flyback protection supervisor
`timescale 1ns/100ps
`default_nettype none

module fps_supervisor_tb
  import fps_pkg::*;
;
  // Stimulus
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        clk_en = 1'b1;
  fps_cmp_t    cmp = '0;
  logic        pwm_on_req = 1'b0;
  logic        protocol_fault = 1'b0;
  logic [7:0]  s_awaddr = '0;
  logic [7:0]  s_araddr = '0;
  logic [31:0] s_wdata = '0;
  logic [3:0]  s_wstrb = '0;
  logic        s_awvalid = 1'b0;
  logic        s_wvalid = 1'b0;
  logic        s_bready = 1'b0;
  logic        s_arvalid = 1'b0;
  logic        s_rready = 1'b0;
  // Observed
  logic        gate_drive, hv_startup_en, sense_clamp_en, power_limit_en;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata;
  // Scoreboard
  int          fail_count = 0;
  int          checks_done = 0;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  // Fault rows: comparator flip, pulse length, sticky cause
  logic [10:0] fmask[7] = '{11'h002, 11'h004, 11'h001, 11'h010, 11'h040, 11'h100, 11'h020};
  int          flen[7] = '{60, 60, 60, 60, 60, 500, 60};
  logic [7:0]  fcause[7] = '{8'h40, 8'h20, 8'h80, 8'h10, 8'h04, 8'h01, 8'h08};

  fps_supervisor #(.LONG_OFF_CYC(20), .BROWNOUT_CYC(10), .UVP_BLANK_CYC(30)) i_dut (
    .aclk, .aresetn, .clk_en, .cmp, .pwm_on_req, .protocol_fault, .gate_drive,
    .hv_startup_en, .sense_clamp_en, .power_limit_en, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready);

  initial forever #20 aclk = ~aclk;

  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One bus transfer; the monitor compares the answer
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] st, input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back(wr ? {1'b1, r, 32'h0} : {1'b0, r, d});
    @(posedge aclk);
    s_awaddr <= a;
    s_araddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= wr;
    s_wvalid <= wr;
    s_bready <= wr;
    s_arvalid <= !wr;
    s_rready <= !wr;
    do begin
      @(posedge aclk);
      n++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_arready) s_arvalid <= 1'b0;
    end while (!(s_bvalid && wr) && !(s_rvalid && !wr) && n < 99);
    if (n >= 99) fail_count++;
    s_bready <= 1'b0;
    s_rready <= 1'b0;
  endtask

  // Answers pair with the oldest note
  always @(posedge aclk) begin
    if ((s_bvalid && s_bready) || (s_rvalid && s_rready)) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      check(s_bvalid ? {1'b1, s_bresp, 32'h0} : {1'b0, s_rresp, s_rdata}, e);
    end
  end

  task automatic pulse(input int len);
    @(posedge aclk);
    pwm_on_req <= 1'b1;
    repeat (len) @(posedge aclk);
    pwm_on_req <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  // Recharge, then brown-in over four pulses
  task automatic bring_up();
    logic pf;
    pf = 1'($urandom);
    @(posedge aclk);
    cmp <= 11'h204;
    protocol_fault <= pf;
    repeat (3) @(posedge aclk);
    check(hv_startup_en, 1'b1);
    cmp <= 11'h484;
    repeat (3) @(posedge aclk);
    check(hv_startup_en, 1'b0);
    repeat (4) pulse(8);
    axi(1'b0, REG_STATUS, {24'h0, 5'(ST_RUN), 1'b0, pf, 1'b0}, 4'h0, RESP_OKAY);
    cmp <= 11'h404;
  endtask

  // Hang guard, well past the longest run
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    complete_run();
  end

  initial begin
    logic [31:0] r;
    void'($urandom(86184));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi(1'b0, REG_CTRL, CTRL_RESET, 4'h0, RESP_OKAY);
    axi(1'b0, REG_STATUS, 32'h4, 4'h0, RESP_OKAY);
    axi(1'b0, 8'h0c, 32'h0, 4'h0, RESP_SLVERR);
    axi(1'b1, 8'h0c, 32'hff, 4'hf, RESP_SLVERR);
    r = $urandom;
    axi(1'b1, REG_CTRL, r, 4'hf, RESP_OKAY);
    axi(1'b1, REG_CTRL, ~r, 4'he, RESP_OKAY);
    axi(1'b0, REG_CTRL, {30'h0, r[1:0]}, 4'h0, RESP_OKAY);
    axi(1'b1, REG_CTRL, 32'h0, 4'hf, RESP_OKAY);
    // Supply comes up but line never qualifies
    cmp <= 11'h404;
    repeat (3) @(posedge aclk);
    check(hv_startup_en, 1'b0);
    cmp <= 11'h204;
    repeat (3) @(posedge aclk);
    axi(1'b0, REG_CAUSE, 32'h2, 4'h0, RESP_OKAY);
    axi(1'b1, REG_CAUSE, 32'hff, 4'hf, RESP_OKAY);
    // Peak limit cuts a pulse short
    bring_up();
    pwm_on_req <= 1'b1;
    repeat (3) @(posedge aclk);
    check(sense_clamp_en, 1'b1);
    cmp <= 11'h40c;
    repeat (3) @(posedge aclk);
    check(gate_drive, 1'b0);
    pwm_on_req <= 1'b0;
    cmp <= 11'h404;
    // Each fault in turn, then restart from scratch
    for (int i = 0; i < 7; i++) begin
      if (i == 6) axi(1'b1, REG_CTRL, 32'h1, 4'hf, RESP_OKAY);
      if (i != 0) bring_up();
      cmp <= 11'h404 ^ fmask[i];
      repeat (6) pulse(flen[i]);
      cmp <= 11'h404;
      axi(1'b0, REG_CAUSE, {24'h0, fcause[i]}, 4'h0, RESP_OKAY);
      axi(1'b1, REG_CAUSE, 32'hff, 4'hf, RESP_OKAY);
    end
    // Latched: recharge must not resume switching
    cmp <= 11'h204;
    repeat (3) @(posedge aclk);
    cmp <= 11'h484;
    repeat (3) @(posedge aclk);
    pwm_on_req <= 1'b1;
    repeat (3) @(posedge aclk);
    check(gate_drive, 1'b0);
    pwm_on_req <= 1'b0;
    axi(1'b1, REG_CTRL, 32'h5, 4'hf, RESP_OKAY);
    bring_up();
    // Long restart: off time first, then recharge
    axi(1'b1, REG_CTRL, 32'h2, 4'hf, RESP_OKAY);
    cmp <= 11'h414;
    repeat (5) pulse(8);
    cmp <= 11'h204;
    repeat (10) @(posedge aclk);
    check(hv_startup_en, 1'b0);
    repeat (20) @(posedge aclk);
    check(hv_startup_en, 1'b1);
    axi(1'b0, REG_CAUSE, 32'h10, 4'h0, RESP_OKAY);
    repeat (5) @(posedge aclk);
    complete_run();
  end
endmodule

`default_nettype wire
